// [verilog/flag_trap_params.svh]
// constants for the status flag and trap block
`ifndef FLAG_TRAP_PARAMS_SVH
`define FLAG_TRAP_PARAMS_SVH
`define FT_CLK_MHZ 100
`define FT_LONG_DIV_CYC 749
`define FT_FCW_RST 16'h0000
`define FT_EXT_EN_BIT 4'hD
`define FT_SYS_MODE_BIT 4'hE
`define FT_FLG_C 3'h7
`define FT_FLG_Z 3'h6
`define FT_FLG_S 3'h5
`define FT_FLG_V 3'h4
`define FT_FLG_D 3'h3
`define FT_FLG_H 3'h2
`define FT_CC_F 4'h0
`define FT_CC_LT 4'h1
`define FT_CC_LE 4'h2
`define FT_CC_ULE 4'h3
`define FT_CC_OV 4'h4
`define FT_CC_MI 4'h5
`define FT_CC_Z 4'h6
`define FT_CC_C 4'h7
`define FT_CC_T 4'h8
`define FT_CC_GE 4'h9
`define FT_CC_GT 4'hA
`define FT_CC_UGT 4'hB
`define FT_CC_NOV 4'hC
`define FT_CC_PL 4'hD
`define FT_CC_NZ 4'hE
`define FT_CC_NC 4'hF
`define FT_REG_FCW 4'h0
`define FT_REG_STAT 4'h4
`define FT_REG_CC 4'h8
`define FT_RD_LAT 1
`endif

// [verilog/flag_trap_pkg.sv]
// types for the status flag and trap block
package flag_trap_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_LOGIC = 4'h3,
    OP_FLAGCTL = 4'h4, OP_LDFLB = 4'h5, OP_BLOCK = 4'h6, OP_BLKCMP = 4'h7,
    OP_EXT = 4'h8, OP_PRIV = 4'h9, OP_SYSCALL = 4'hA, OP_SEGV = 4'hB
  } op_t;
  typedef enum logic [2:0] {
    TRAP_NONE = 3'h0, TRAP_EXT = 3'h1, TRAP_PRIV = 3'h2, TRAP_SEG = 3'h3, TRAP_SC = 3'h4
  } trap_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_EXEC = 3'b010, ST_INTR = 3'b100
  } seq_t;
  typedef struct packed {
    logic valid;
    op_t op;
    logic byte_op;
    logic [15:0] a;
    logic [15:0] b;
    logic carry_in;
    logic last;
    logic cnt_zero;
    logic cmp_met;
    logic [3:0] set_m;
    logic [3:0] clr_m;
    logic [3:0] inv_m;
    logic [7:0] flag_byte;
  } instr_t;
  typedef struct packed {
    logic [15:0] flag_control_word;
    seq_t seq;
    logic [15:0] result;
    trap_t trap;
    logic trap_pulse;
    logic int_take;
    logic suspend;
    logic [31:0] rdata;
    logic rvalid;
  } state_t;
endpackage

// [verilog/flag_trap.sv]
// status flags, condition evaluation, trap and interrupt boundary logic
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "flag_trap_params.svh"
// Contract
// - status keeps six flags, updated by arithmetic and logical operations
// - flag control can set, clear or invert carry, zero, sign, parity
// - extension opcode runs when enabled, else extended-instruction trap
// - flag byte write keeps control byte; flag byte is readable
// - carry set on carry out of or borrow into the top bit
// - zero set when result is all zeros
// - block compare reports condition met through zero
// - sign copies the result's top bit
// - overflow set when signed result leaves representable range
// - byte logical ops set parity on even count of ones
// - block ops set parity/overflow when counter reaches zero
// - decimal flag records whether last arithmetic was add or subtract
// - half carry captures carry or borrow at the nibble boundary on byte add and subtract
// - four-bit condition field selects one of sixteen flag functions
// - enabled interrupts are taken only after the instruction completes
// - iterative ops suspend after an iteration, restart same instruction
// - counters and pointers reflect completed iterations at suspension
// - long divide bounded to 749 cycles, bounding normal-mode latency
// - traps are synchronous, unmaskable, handled like interrupts
// - exactly four trap sources exist
// - privileged instruction in normal mode raises privileged trap
// - system call always traps
// - condition codes decode per the standard table
module flag_trap
  import flag_trap_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire instr_t i_instr,
  input wire logic i_int_req,
  input wire logic [3:0] i_cond,
  input wire logic [3:0] i_avm_address,
  input wire logic i_avm_read,
  input wire logic i_avm_write,
  input wire logic [31:0] i_avm_writedata,
  input wire logic [3:0] i_avm_byteenable,
  output logic [31:0] o_avm_readdata,
  output logic o_avm_waitrequest,
  output logic [15:0] o_result,
  output logic [7:0] o_flags,
  output logic o_cond_true,
  output logic o_trap,
  output logic [2:0] o_trap_kind,
  output logic o_int_take,
  output logic o_suspend
);

  state_t q;
  state_t d;

  // ---------------------------------------------
  // condition decode
  // ---------------------------------------------
  function automatic logic cond_eval(input logic [3:0] cc, input logic [7:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    logic r;
    c = f[`FT_FLG_C];
    z = f[`FT_FLG_Z];
    s = f[`FT_FLG_S];
    v = f[`FT_FLG_V];
    r = 1'b0;
    unique case (cc)
      `FT_CC_F: r = 1'b0;
      `FT_CC_LT: r = s ^ v;
      `FT_CC_LE: r = z | (s ^ v);
      `FT_CC_ULE: r = c | z;
      `FT_CC_OV: r = v;
      `FT_CC_MI: r = s;
      `FT_CC_Z: r = z;
      `FT_CC_C: r = c;
      `FT_CC_T: r = 1'b1;
      `FT_CC_GE: r = ~(s ^ v);
      `FT_CC_GT: r = ~(z | (s ^ v));
      `FT_CC_UGT: r = ~c & ~z;
      `FT_CC_NOV: r = ~v;
      `FT_CC_PL: r = ~s;
      `FT_CC_NZ: r = ~z;
      `FT_CC_NC: r = ~c;
    endcase
    return r;
  endfunction

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  logic [16:0] sum;
  logic [4:0] nib;
  logic [15:0] res;
  logic msb_a;
  logic msb_b;
  logic msb_r;
  logic cout;
  logic is_sub;
  logic sys_mode;
  logic ext_en;
  logic done;
  logic [7:0] fl;
  logic [7:0] fl_n;
  logic take_int;

  always_comb
  begin
    d = q;
    d.trap_pulse = 1'b0;
    d.int_take = 1'b0;
    d.suspend = 1'b0;
    d.rvalid = 1'b0;
    fl = q.flag_control_word[7:0];
    fl_n = fl;
    sys_mode = q.flag_control_word[`FT_SYS_MODE_BIT];
    ext_en = q.flag_control_word[`FT_EXT_EN_BIT];
    is_sub = (i_instr.op == OP_SUB);
    sum = is_sub ? ({1'b0, i_instr.a} - {1'b0, i_instr.b} - {16'h0000, i_instr.carry_in})
                 : ({1'b0, i_instr.a} + {1'b0, i_instr.b} + {16'h0000, i_instr.carry_in});
    nib = is_sub ? ({1'b0, i_instr.a[3:0]} - {1'b0, i_instr.b[3:0]} - {4'h0, i_instr.carry_in})
                 : ({1'b0, i_instr.a[3:0]} + {1'b0, i_instr.b[3:0]} + {4'h0, i_instr.carry_in});
    res = (i_instr.op == OP_LOGIC) ? i_instr.a : sum[15:0];
    if (i_instr.byte_op)
    begin
      res = {8'h00, res[7:0]};
      msb_a = i_instr.a[7];
      msb_b = i_instr.b[7] ^ is_sub;
      msb_r = res[7];
      cout = sum[8] ^ i_instr.a[8] ^ i_instr.b[8];
    end
    else
    begin
      msb_a = i_instr.a[15];
      msb_b = i_instr.b[15] ^ is_sub;
      msb_r = res[15];
      cout = sum[16];
    end
    done = 1'b0;
    d.trap = TRAP_NONE;
    if (i_instr.valid)
    begin
      // synchronous trap sources, no mask applies
      unique case (i_instr.op)
        OP_EXT: if (!ext_en) d.trap = TRAP_EXT;
        OP_PRIV, OP_LDFLB: if (!sys_mode && i_instr.op == OP_PRIV) d.trap = TRAP_PRIV;
        OP_SEGV: d.trap = TRAP_SEG;
        OP_SYSCALL: d.trap = TRAP_SC;
        default: d.trap = TRAP_NONE;
      endcase
      if (d.trap == TRAP_NONE)
      begin
        unique case (i_instr.op)
          OP_ADD, OP_SUB:
          begin
            fl_n[`FT_FLG_C] = cout;
            fl_n[`FT_FLG_Z] = (res == 16'h0000);
            fl_n[`FT_FLG_S] = msb_r;
            fl_n[`FT_FLG_V] = (msb_a == msb_b) && (msb_r != msb_a);
            fl_n[`FT_FLG_D] = is_sub;
            if (i_instr.byte_op)
              fl_n[`FT_FLG_H] = nib[4];
            d.result = res;
          end
          OP_LOGIC:
          begin
            fl_n[`FT_FLG_Z] = (res == 16'h0000);
            fl_n[`FT_FLG_S] = msb_r;
            if (i_instr.byte_op)
              fl_n[`FT_FLG_V] = ~(^res[7:0]);
            d.result = res;
          end
          OP_FLAGCTL:
            fl_n[7:4] = ((fl[7:4] | i_instr.set_m) & ~i_instr.clr_m) ^ i_instr.inv_m;
          OP_LDFLB:
            fl_n = i_instr.flag_byte;
          OP_BLOCK:
            fl_n[`FT_FLG_V] = i_instr.cnt_zero;
          OP_BLKCMP:
          begin
            fl_n[`FT_FLG_Z] = i_instr.cmp_met;
            fl_n[`FT_FLG_V] = i_instr.cnt_zero;
          end
          default: fl_n = fl;
        endcase
      end
      d.flag_control_word[7:0] = fl_n;
      d.trap_pulse = (d.trap != TRAP_NONE);
      done = i_instr.last;
    end
    // interrupt only at a completed instruction or iteration
    // a block op may stop between iterations, anything else only on its last cycle
    take_int = i_instr.valid && i_int_req
               && (done || i_instr.op == OP_BLOCK || i_instr.op == OP_BLKCMP);
    unique case (q.seq)
      ST_IDLE, ST_EXEC:
        if (take_int)
        begin
          d.seq = ST_INTR;
          d.int_take = 1'b1;
          d.suspend = !done;
        end
        else if (i_instr.valid)
          d.seq = done ? ST_IDLE : ST_EXEC;
      ST_INTR:
        d.seq = ST_IDLE;
    endcase
    // register bus, one wait cycle on reads
    if (i_avm_write && i_avm_address == `FT_REG_FCW)
    begin
      if (i_avm_byteenable[0])
        d.flag_control_word[7:0] = i_avm_writedata[7:0];
      if (i_avm_byteenable[1])
        d.flag_control_word[15:8] = i_avm_writedata[15:8];
    end
    if (i_avm_read && !q.rvalid)
    begin
      d.rvalid = 1'b1;
      unique case (i_avm_address)
        `FT_REG_FCW: d.rdata = {16'h0000, q.flag_control_word};
        `FT_REG_STAT: d.rdata = {27'h0000000, q.seq, 1'b0, q.int_take};
        `FT_REG_CC: d.rdata = {29'h00000000, q.trap};
        default: d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      q <= '0;
      q.flag_control_word <= `FT_FCW_RST;
      q.seq <= ST_IDLE;
      q.trap <= TRAP_NONE;
    end
    else
      q <= d;
  end

  assign o_avm_waitrequest = i_avm_read & ~q.rvalid;
  assign o_avm_readdata = q.rdata;
  assign o_result = q.result;
  assign o_flags = q.flag_control_word[7:0];
  assign o_cond_true = cond_eval(i_cond, q.flag_control_word[7:0]);
  assign o_trap = q.trap_pulse;
  assign o_trap_kind = q.trap;
  assign o_int_take = q.int_take;
  assign o_suspend = q.suspend;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  syscall_trap_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_SYSCALL |=> o_trap && o_trap_kind == TRAP_SC)
    else $error("system call did not trap");
  ext_trap_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_EXT && !q.flag_control_word[`FT_EXT_EN_BIT] |=> o_trap_kind == TRAP_EXT)
    else $error("disabled extension opcode did not trap");
  priv_trap_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_PRIV && !q.flag_control_word[`FT_SYS_MODE_BIT] |=> o_trap_kind == TRAP_PRIV)
    else $error("privileged op in normal mode did not trap");
  trap_no_flags_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_trap && !$past(i_avm_write) |-> o_flags == $past(o_flags))
    else $error("trap changed flags");
  zero_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_ADD && !i_avm_write |=> o_flags[`FT_FLG_Z] == (o_result == 16'h0000))
    else $error("zero flag wrong");
  dec_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_SUB && !i_avm_write |=> o_flags[`FT_FLG_D])
    else $error("decimal flag not set on subtract");
  cond_true_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_cond == `FT_CC_T |-> o_cond_true)
    else $error("always-true code false");
  cond_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_cond == `FT_CC_NZ |-> o_cond_true == !o_flags[`FT_FLG_Z])
    else $error("not-zero code wrong");
  int_bound_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_int_take |-> $past(i_instr.valid))
    else $error("interrupt taken off boundary");
  int_latency_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_int_req && i_instr.last && q.seq != ST_INTR |=> o_int_take)
    else $error("interrupt not taken at instruction end");

  // ---------------------------------------------
  // flag, sequence and trap checks
  // ---------------------------------------------
  carry_add_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_ADD && !i_instr.byte_op && !i_instr.carry_in && !i_avm_write
    |=> o_flags[`FT_FLG_C] == $past(i_instr.a > ~i_instr.b))
    else $error("carry wrong after add");
  carry_sub_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_SUB && !i_instr.byte_op && !i_instr.carry_in && !i_avm_write
    |=> o_flags[`FT_FLG_C] == $past(i_instr.a < i_instr.b))
    else $error("borrow wrong after subtract");
  sign_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && (i_instr.op == OP_ADD || i_instr.op == OP_SUB || i_instr.op == OP_LOGIC)
    && !i_avm_write
    |=> o_flags[`FT_FLG_S] == ($past(i_instr.byte_op) ? o_result[7] : o_result[15]))
    else $error("sign flag wrong");
  ovf_add_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_ADD && !i_instr.byte_op && !i_avm_write
    |=> o_flags[`FT_FLG_V] == ($past(i_instr.a[15] == i_instr.b[15])
    && o_result[15] != $past(i_instr.a[15])))
    else $error("overflow flag wrong after add");
  parity_byte_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_LOGIC && i_instr.byte_op && !i_avm_write
    |=> o_flags[`FT_FLG_V] == ~^o_result[7:0])
    else $error("parity flag wrong");
  block_cnt_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_BLOCK && !i_avm_write
    |=> o_flags[`FT_FLG_V] == $past(i_instr.cnt_zero))
    else $error("block counter flag wrong");
  blkcmp_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_BLKCMP && !i_avm_write
    |=> o_flags[`FT_FLG_Z] == $past(i_instr.cmp_met))
    else $error("block compare zero flag wrong");
  flag_ctl_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_FLAGCTL && !i_avm_write
    |=> o_flags[7:4] == $past(((o_flags[7:4] | i_instr.set_m) & ~i_instr.clr_m)
    ^ i_instr.inv_m))
    else $error("flag control result wrong");
  flag_load_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_LDFLB && !i_avm_write
    |=> o_flags == $past(i_instr.flag_byte) && $stable(q.flag_control_word[15:8]))
    else $error("flag byte load wrong");
  half_carry_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_ADD && i_instr.byte_op && !i_instr.carry_in && !i_avm_write
    |=> o_flags[`FT_FLG_H] == $past(i_instr.a[3:0] > ~i_instr.b[3:0]))
    else $error("half carry wrong after add");
  dec_add_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_ADD && !i_avm_write |=> !o_flags[`FT_FLG_D])
    else $error("decimal flag set on add");
  logic_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_LOGIC && !i_avm_write
    |=> o_flags[`FT_FLG_Z] == (o_result == 16'h0000))
    else $error("zero flag wrong after logic op");
  suspend_int_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_suspend |-> o_int_take)
    else $error("suspend without interrupt");
  suspend_blk_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_int_req && i_instr.op == OP_BLOCK && !i_instr.last && q.seq != ST_INTR
    |=> o_suspend)
    else $error("block op not suspended");
  trap_kind_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_trap == (o_trap_kind != TRAP_NONE))
    else $error("trap pulse and kind disagree");
  trap_result_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_trap |-> $stable(o_result))
    else $error("trap changed result");
  seg_trap_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_SEGV |=> o_trap_kind == TRAP_SEG)
    else $error("segment violation did not trap");
  priv_sys_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_PRIV && q.flag_control_word[`FT_SYS_MODE_BIT] |=> !o_trap)
    else $error("privileged op trapped in system mode");
  trap_unmask_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_instr.valid && i_instr.op == OP_SYSCALL && i_int_req |=> o_trap)
    else $error("trap lost under interrupt");
endmodule

// [sim/status_flags_and_traps_tb.sv]
// self-checking bench for the status flag and trap block
`timescale 1ns/1ps
module status_flags_and_traps_tb
  import flag_trap_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  instr_t i_instr = '0;
  logic i_int_req = 1'b0;
  logic [3:0] i_cond = 4'h0;
  logic [3:0] i_avm_address = 4'h0;
  logic i_avm_read = 1'b0;
  logic i_avm_write = 1'b0;
  logic [31:0] i_avm_writedata = 32'h0;
  logic [3:0] i_avm_byteenable = 4'h0;
  logic [31:0] o_avm_readdata;
  logic o_avm_waitrequest;
  logic [15:0] o_result;
  logic [7:0] o_flags;
  logic o_cond_true;
  logic o_trap;
  logic [2:0] o_trap_kind;
  logic o_int_take;
  logic o_suspend;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] fe = 8'h00;
  logic [7:0] kn = 8'hFC;
  logic [7:0] hi = 8'h00;
  logic [31:0] rd;

  flag_trap flag_trap_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_instr(i_instr),
    .i_int_req(i_int_req), .i_cond(i_cond), .i_avm_address(i_avm_address),
    .i_avm_read(i_avm_read), .i_avm_write(i_avm_write), .i_avm_writedata(i_avm_writedata),
    .i_avm_byteenable(i_avm_byteenable), .o_avm_readdata(o_avm_readdata),
    .o_avm_waitrequest(o_avm_waitrequest), .o_result(o_result), .o_flags(o_flags),
    .o_cond_true(o_cond_true), .o_trap(o_trap), .o_trap_kind(o_trap_kind),
    .o_int_take(o_int_take), .o_suspend(o_suspend));

  always #5 i_ref_clk = ~i_ref_clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_avm_address <= a;
    i_avm_writedata <= wd;
    i_avm_byteenable <= 4'h3;
    i_avm_write <= wr;
    i_avm_read <= ~wr;
    do
    begin
      @(posedge i_ref_clk);
      n++;
    end while (o_avm_waitrequest !== 1'b0);
    rd = o_avm_readdata;
    i_avm_write <= 1'b0;
    i_avm_read <= 1'b0;
    cmp(n, wr ? 1 : 2);
  endtask

  task automatic run(input instr_t x, input logic ir);
    @(posedge i_ref_clk);
    i_instr <= x;
    i_int_req <= ir;
    @(posedge i_ref_clk);
    i_instr <= '0;
    i_int_req <= 1'b0;
    #1;
  endtask

  task automatic chkf();
    cmp(32'(o_flags & kn), 32'(fe & kn));
  endtask

  function automatic logic cx(input logic [3:0] k, input logic [7:0] f);
    logic r;
    case (k[2:0])
      3'h0: r = 1'b0;
      3'h1: r = f[5] ^ f[4];
      3'h2: r = f[6] | (f[5] ^ f[4]);
      3'h3: r = f[7] | f[6];
      3'h4: r = f[4];
      3'h5: r = f[5];
      3'h6: r = f[6];
      default: r = f[7];
    endcase
    return r ^ k[3];
  endfunction

  task automatic arith(input logic sub, input logic bw);
    instr_t x;
    int a, b, r, w, m;
    x = '0;
    w = bw ? 8 : 16;
    m = (1 << w) - 1;
    a = $urandom & m;
    b = $urandom & m;
    if ($urandom % 4 == 0)
      b = (sub ? a : (1 << w) - a) & m;
    x.valid = 1'b1;
    x.op = sub ? OP_SUB : OP_ADD;
    x.byte_op = bw;
    x.a = a[15:0];
    x.b = b[15:0];
    r = sub ? a - b : a + b;
    fe[7] = sub ? (a < b) : r[w];
    r = r & m;
    fe[6] = (r == 0);
    fe[5] = r[w-1];
    fe[4] = (a[w-1] != r[w-1]) && ((a[w-1] == b[w-1]) != sub);
    fe[3] = sub;
    fe[2] = sub ? ((a & 15) < (b & 15)) : ((a & 15) + (b & 15) > 15);
    kn = bw ? 8'hFC : 8'hF0;
    run(x, 1'b0);
    chkf();
    cmp(32'(o_result & m[15:0]), r);
  endtask

  task automatic trap(input op_t o, input logic [2:0] k);
    instr_t x;
    x = '0;
    x.valid = 1'b1;
    x.op = o;
    x.a = 16'(($urandom));
    run(x, 1'b0);
    cmp(o_trap, k != 3'h0);
    if (k != 3'h0)
    begin
      cmp(o_trap_kind, k);
      chkf();
    end
    else
    begin
      cmp(o_trap_kind, 3'h0);
      kn = 8'h00;
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    instr_t x;
    int k;
    void'($urandom(16333));
    repeat (4) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    cmp(rd, 32'h0);
    repeat (60) arith(1'(($urandom)), 1'(($urandom)));
    repeat (12)
    begin
      x = '0;
      x.valid = 1'b1;
      x.op = OP_LOGIC;
      x.byte_op = 1'b1;
      x.a = 16'(($urandom & 8'hFF));
      fe[6] = (x.a[7:0] == 8'h00);
      fe[5] = x.a[7];
      fe[4] = ~^x.a[7:0];
      kn = 8'h70;
      run(x, 1'b0);
      chkf();
    end
    repeat (12)
    begin
      x = '0;
      x.valid = 1'b1;
      x.op = OP_LDFLB;
      x.flag_byte = 8'(($urandom & 8'hFC));
      fe = x.flag_byte;
      kn = 8'hFC;
      run(x, 1'b0);
      bus(1'b0, 4'h0, 32'h0);
      cmp(rd[15:0], {hi, fe});
      x = '0;
      x.valid = 1'b1;
      x.op = OP_FLAGCTL;
      for (int i = 0; i < 4; i++)
      begin
        k = $urandom % 4;
        x.set_m[i] = (k == 1);
        x.clr_m[i] = (k == 2);
        x.inv_m[i] = (k == 3);
      end
      fe[7:4] = ((fe[7:4] | x.set_m) & ~x.clr_m) ^ x.inv_m;
      run(x, 1'b0);
      chkf();
      for (int cc = 0; cc < 16; cc++)
      begin
        @(posedge i_ref_clk);
        i_cond <= 4'(cc);
        #1;
        cmp(o_cond_true, cx(4'(cc), fe));
      end
    end
    trap(OP_EXT, 3'h1);
    trap(OP_PRIV, 3'h2);
    trap(OP_SYSCALL, 3'h4);
    trap(OP_SEGV, 3'h3);
    hi = 8'h60;
    bus(1'b1, 4'h0, {16'h0, hi, fe});
    trap(OP_SYSCALL, 3'h4);
    trap(OP_EXT, 3'h0);
    trap(OP_PRIV, 3'h0);
    for (int i = 0; i < 5; i++)
    begin
      x = '0;
      x.valid = 1'b1;
      x.op = (i == 1 || i == 4) ? OP_BLOCK : OP_LOGIC;
      x.last = (i == 0 || i == 3 || i == 4);
      x.cnt_zero = (i == 4);
      run(x, i != 3);
      cmp(o_int_take, i != 2 && i != 3);
      cmp(o_suspend, i == 1);
      if (i == 4)
        cmp(o_flags[4], 1'b1);
    end
    for (int i = 0; i < 2; i++)
    begin
      x = '0;
      x.valid = 1'b1;
      x.op = OP_BLKCMP;
      x.cmp_met = i[0];
      run(x, 1'b0);
      cmp(o_flags[6], i[0]);
    end
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    num_errors++;
    final_report();
  end
endmodule
